// *** pkg/nvp_pkg.sv ***
// Notes on behaviour
// - flash changes only in whole pages
// - region edges from fuses, 256-byte blocks
// - loader end zero: all flash is loader
// - code end zero: code runs to end
// - code end not above loader: no code region
// - code end above loader: data follows code
// - fuse edge beyond flash: use default
// - loader writes code/data, code writes data
// - data-region code may write nothing
// - loader lock set in loader, acts outside
// - code write protect blocks code-region writes
// - eeprom changes only marked bytes
// - user row debug-writable while locked
// - array access during operation waits
// - one shared buffer, one memory per fill
// - store ANDs data into buffer slot
// - buffer all ones after reset/op/clear/wake
// - write page copies buffer, then clears
// - wipe needs a stored byte for address
// - flash wipe erases page, halts cpu
// - eeprom wipe erases marked bytes only
// - after reset writes rejected, busy reads one
// - wipe-and-program keeps buffer between steps
package nvp_pkg;
    localparam int PAGE_BYTES = 64;
    localparam int OFS_W = 6;
    localparam int FLASH_BYTES = 8192;
    localparam int BLOCK_BYTES = 256;
    localparam int CLK_NS = 10;
    localparam int POR_TOUT_NS = 2000;
    localparam int POR_TOUT_CYC = (POR_TOUT_NS + CLK_NS - 1) / CLK_NS;
    localparam int KEY_WINDOW = 4;
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_PROT = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_KEY = 8'h04;
    localparam logic [7:0] KEY_SELF_PROG = 8'h9d;
    localparam logic [7:0] KEY_IO = 8'hd8;
    localparam int PROT_WP_BIT = 0;
    localparam int PROT_LOCK_BIT = 1;
    localparam int STAT_WERR_BIT = 2;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0, CMD_WRITE_PAGE = 3'h1, CMD_PAGE_WIPE = 3'h2,
        CMD_WIPE_PROG = 3'h3, CMD_CLR_BUF = 3'h4
    } nvp_cmd_t;
    typedef enum logic [1:0] {
        SP_FLASH = 2'h0, SP_EEPROM = 2'h1, SP_USER = 2'h2
    } nvp_space_t;
    typedef enum logic [1:0] {
        RG_LOADER = 2'h0, RG_CODE = 2'h1, RG_DATA = 2'h2
    } nvp_region_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_ERASE = 2'b01, ST_WRITE = 2'b11
    } nvp_state_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'h0, OP_ERASE = 2'h1, OP_WRITE = 2'h2
    } nvp_op_t;
    typedef struct packed {
        nvp_op_t op;
        nvp_space_t space;
        logic [15:0] page;
        logic [PAGE_BYTES-1:0][7:0] data;
        logic [PAGE_BYTES-1:0] mask;
    } nvp_nvm_req_t;
    typedef struct packed {
        nvp_state_t st;
        logic [15:0] por_cnt;
        logic [2:0] key_win;
        logic key_self;
        logic key_io;
        logic lock;
        logic wp;
        logic werr;
        logic then_write;
        logic any;
        nvp_space_t space;
        logic [15:0] page;
        logic [PAGE_BYTES-1:0][7:0] buf_data;
        logic [PAGE_BYTES-1:0] mark;
        logic [7:0] rdata;
    } nvp_regs_t;
endpackage : nvp_pkg

// *** rtl/nvp_ctrl.sv ***
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module nvp_ctrl #(
    parameter int FLASH_BYTES = nvp_pkg::FLASH_BYTES,
    parameter logic [7:0] LOADER_END_DEFAULT = 8'h00,
    parameter logic [7:0] APP_END_DEFAULT = 8'h00,
    parameter int POR_CYCLES = nvp_pkg::POR_TOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic [15:0] i_mem_addr,
    input wire logic [7:0] i_mem_wdata,
    input wire nvp_pkg::nvp_space_t i_mem_space,
    input wire logic i_mem_wr,
    input wire logic i_mem_rd,
    input wire logic i_mem_dbg,
    output logic o_mem_wait,
    output logic o_mem_deny,
    input wire logic [15:0] i_pc,
    input wire logic i_instr_done,
    input wire logic i_dev_locked,
    input wire logic i_wake,
    input wire logic [7:0] i_loader_end_fuse,
    input wire logic [7:0] i_app_code_end_fuse,
    output logic o_cpu_halt,
    output logic o_loader_blocked,
    output nvp_pkg::nvp_nvm_req_t o_nvm_req,
    input wire logic i_nvm_done
);
    // ----------------------------------------
    // region map
    // ----------------------------------------
    localparam logic [8:0] FLASH_BLKS =
        9'(FLASH_BYTES / nvp_pkg::BLOCK_BYTES);

    function automatic nvp_pkg::nvp_region_t region_of(
        input logic [15:0] addr, input logic [7:0] le, input logic [7:0] ae);
        logic [7:0] blk;
        blk = addr[15:8];
        if (le == 8'h00) begin
            region_of = nvp_pkg::RG_LOADER;
        end else if (blk < le) begin
            region_of = nvp_pkg::RG_LOADER;
        end else if (ae == 8'h00) begin
            region_of = nvp_pkg::RG_CODE;
        end else if (ae <= le) begin
            region_of = nvp_pkg::RG_DATA;
        end else if (blk < ae) begin
            region_of = nvp_pkg::RG_CODE;
        end else begin
            region_of = nvp_pkg::RG_DATA;
        end
    endfunction : region_of

    function automatic nvp_pkg::nvp_regs_t clr_buf(
        input nvp_pkg::nvp_regs_t r);
        nvp_pkg::nvp_regs_t t;
        t = r;
        t.buf_data = '1;
        t.mark = '0;
        t.any = 1'b0;
        clr_buf = t;
    endfunction : clr_buf

    nvp_pkg::nvp_regs_t s;
    nvp_pkg::nvp_regs_t next_s;
    logic [7:0] le;
    logic [7:0] ae;
    nvp_pkg::nvp_region_t pc_rg;
    nvp_pkg::nvp_region_t tgt_rg;
    nvp_pkg::nvp_region_t rd_rg;
    logic busy;
    logic por;
    logic flash_busy;
    logic ee_busy;
    logic store_ok;
    logic cmd_wr;
    logic allowed;
    logic [nvp_pkg::OFS_W-1:0] ofs;

    // out-of-range fuse falls back to default
    assign le = ({1'b0, i_loader_end_fuse} > FLASH_BLKS) ?
        LOADER_END_DEFAULT : i_loader_end_fuse;
    assign ae = ({1'b0, i_app_code_end_fuse} > FLASH_BLKS) ?
        APP_END_DEFAULT : i_app_code_end_fuse;
    assign pc_rg = region_of(i_pc, le, ae);
    assign tgt_rg = region_of(s.page, le, ae);
    assign rd_rg = region_of(i_mem_addr, le, ae);
    assign ofs = i_mem_addr[nvp_pkg::OFS_W-1:0];

    // ----------------------------------------
    // status and cpu side
    // ----------------------------------------
    assign busy = s.st != nvp_pkg::ST_IDLE;
    assign por = s.por_cnt != 16'h0000;
    assign flash_busy = por | (busy & s.space == nvp_pkg::SP_FLASH);
    assign ee_busy = por | (busy & s.space != nvp_pkg::SP_FLASH);
    assign o_mem_wait = (i_mem_rd | i_mem_wr) & busy;
    assign o_cpu_halt = busy & s.space == nvp_pkg::SP_FLASH;
    assign o_loader_blocked = s.lock & pc_rg != nvp_pkg::RG_LOADER;
    assign o_mem_deny = i_mem_rd & i_mem_space == nvp_pkg::SP_FLASH &
        rd_rg == nvp_pkg::RG_LOADER & o_loader_blocked;

    // a locked part takes only user-row stores from the debug port
    assign store_ok = i_mem_wr & !busy & !por &
        !(i_dev_locked & i_mem_dbg &
        i_mem_space != nvp_pkg::SP_USER) &
        (!s.any | i_mem_space == s.space);

    // the key arms the command write for four instructions only
    assign cmd_wr = i_reg_wr & i_reg_addr == nvp_pkg::ADDR_CMD &
        s.key_self & !busy & !por;

    always_comb begin
        if (s.space == nvp_pkg::SP_FLASH) begin
            unique case (tgt_rg)
                nvp_pkg::RG_LOADER: allowed = 1'b0;
                nvp_pkg::RG_CODE: allowed =
                    pc_rg == nvp_pkg::RG_LOADER & !s.wp;
                default: allowed = pc_rg != nvp_pkg::RG_DATA;
            endcase
        end else begin
            allowed = pc_rg != nvp_pkg::RG_DATA;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (por) begin
            next_s.por_cnt = s.por_cnt - 16'h0001;
        end
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                nvp_pkg::ADDR_PROT: next_s.rdata = {6'h00, s.lock, s.wp};
                nvp_pkg::ADDR_STATUS:
                    next_s.rdata = {5'h00, s.werr, ee_busy, flash_busy};
                nvp_pkg::ADDR_KEY:
                    next_s.rdata = {6'h00, s.key_self, s.key_io};
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (i_instr_done && s.key_win != 3'h0) begin
            next_s.key_win = s.key_win - 3'h1;
            if (s.key_win == 3'h1) begin
                next_s.key_self = 1'b0;
                next_s.key_io = 1'b0;
            end
        end
        if (i_reg_wr && i_reg_addr == nvp_pkg::ADDR_KEY) begin
            next_s.key_win = 3'(nvp_pkg::KEY_WINDOW);
            next_s.key_self = i_reg_wdata == nvp_pkg::KEY_SELF_PROG;
            next_s.key_io = i_reg_wdata == nvp_pkg::KEY_IO;
        end
        if (i_reg_wr && i_reg_addr == nvp_pkg::ADDR_PROT && s.key_io) begin
            next_s.wp = s.wp | i_reg_wdata[nvp_pkg::PROT_WP_BIT];
            next_s.lock = s.lock | (i_reg_wdata[nvp_pkg::PROT_LOCK_BIT] &
                pc_rg == nvp_pkg::RG_LOADER);
            next_s.key_io = 1'b0;
        end
        if (i_reg_wr && i_reg_addr == nvp_pkg::ADDR_STATUS &&
                i_reg_wdata[nvp_pkg::STAT_WERR_BIT]) begin
            next_s.werr = 1'b0;
        end
        if (store_ok) begin
            next_s.buf_data[ofs] = s.buf_data[ofs] & i_mem_wdata;
            next_s.mark[ofs] = 1'b1;
            next_s.any = 1'b1;
            next_s.space = i_mem_space;
            next_s.page = {i_mem_addr[15:nvp_pkg::OFS_W],
                {nvp_pkg::OFS_W{1'b0}}};
        end
        if (i_wake && !busy) begin
            next_s = clr_buf(next_s);
        end
        if (cmd_wr) begin
            next_s.key_self = 1'b0;
            unique case (i_reg_wdata[2:0])
                nvp_pkg::CMD_CLR_BUF: next_s = clr_buf(next_s);
                nvp_pkg::CMD_WRITE_PAGE,
                nvp_pkg::CMD_PAGE_WIPE,
                nvp_pkg::CMD_WIPE_PROG: begin
                    if (!s.any) begin
                        next_s.st = nvp_pkg::ST_IDLE;
                    end else if (!allowed) begin
                        next_s.werr = 1'b1;
                    end else if (i_reg_wdata[2:0] ==
                            nvp_pkg::CMD_WRITE_PAGE) begin
                        next_s.st = nvp_pkg::ST_WRITE;
                    end else begin
                        next_s.st = nvp_pkg::ST_ERASE;
                        next_s.then_write = i_reg_wdata[2:0] ==
                            nvp_pkg::CMD_WIPE_PROG;
                    end
                end
                default: next_s.st = s.st;
            endcase
        end
        if (i_nvm_done) begin
            unique case (s.st)
                nvp_pkg::ST_ERASE: begin
                    if (s.then_write) begin
                        next_s.st = nvp_pkg::ST_WRITE;
                    end else begin
                        next_s.st = nvp_pkg::ST_IDLE;
                        next_s = clr_buf(next_s);
                    end
                end
                nvp_pkg::ST_WRITE: begin
                    next_s.st = nvp_pkg::ST_IDLE;
                    next_s = clr_buf(next_s);
                end
                default: next_s.st = s.st;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
            s.st <= nvp_pkg::ST_IDLE;
            s.por_cnt <= 16'(POR_CYCLES);
            s.buf_data <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // array request
    // ----------------------------------------
    always_comb begin
        o_nvm_req.op = nvp_pkg::OP_NONE;
        if (s.st == nvp_pkg::ST_ERASE) begin
            o_nvm_req.op = nvp_pkg::OP_ERASE;
        end else if (s.st == nvp_pkg::ST_WRITE) begin
            o_nvm_req.op = nvp_pkg::OP_WRITE;
        end
        o_nvm_req.space = s.space;
        o_nvm_req.page = s.page;
        o_nvm_req.data = s.buf_data;
        // flash has no byte granularity, eeprom only marked bytes
        o_nvm_req.mask = (s.space == nvp_pkg::SP_FLASH) ? '1 :
            s.mark;
    end
    assign o_reg_rdata = s.rdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_read_waits: assert property (i_mem_rd &&
        o_nvm_req.op != nvp_pkg::OP_NONE |-> o_mem_wait)
        else $error("read not stalled during operation");
    a_buf_and: assert property (store_ok |=> s.buf_data[$past(ofs)] ==
        ($past(s.buf_data[ofs]) & $past(i_mem_wdata)))
        else $error("buffer store is not an and");
    a_write_clear: assert property (s.st == nvp_pkg::ST_WRITE &&
        i_nvm_done |=> !s.any && (&s.buf_data) && !busy)
        else $error("buffer not cleared after write");
    a_wipe_and_program_page_cmd_keep: assert property (s.st == nvp_pkg::ST_ERASE && i_nvm_done
        && s.then_write |=> s.st == nvp_pkg::ST_WRITE && s.any)
        else $error("buffer lost between wipe and program");
    a_wipe_needs: assert property (cmd_wr && !s.any |=> !busy)
        else $error("wipe started with empty buffer");
    a_data_reject: assert property (cmd_wr && s.any &&
        i_reg_wdata[2:0] inside {nvp_pkg::CMD_WRITE_PAGE,
        nvp_pkg::CMD_PAGE_WIPE, nvp_pkg::CMD_WIPE_PROG} &&
        pc_rg == nvp_pkg::RG_DATA |=> !busy && s.werr)
        else $error("data region code started a write");
    a_wp_block: assert property (cmd_wr && s.wp && s.space ==
        nvp_pkg::SP_FLASH && tgt_rg == nvp_pkg::RG_CODE |=> !busy)
        else $error("protected code region written");
    a_flash_mask: assert property (o_nvm_req.op != nvp_pkg::OP_NONE &&
        s.space == nvp_pkg::SP_FLASH |-> &o_nvm_req.mask)
        else $error("partial flash page operation");
    a_por_busy: assert property ($fell(i_rst) |->
        (flash_busy && ee_busy) [*2])
        else $error("busy not shown after reset");
    a_loader_all: assert property (le == 8'h00 |->
        pc_rg == nvp_pkg::RG_LOADER)
        else $error("zero loader end not all loader");

    c_wipe_and_program_page_cmd: cover property (s.st == nvp_pkg::ST_ERASE && s.then_write
        ##[1:100] s.st == nvp_pkg::ST_WRITE);
    c_ee_write: cover property (s.st == nvp_pkg::ST_WRITE &&
        s.space == nvp_pkg::SP_EEPROM && i_nvm_done);
    c_flash_wipe: cover property (s.st == nvp_pkg::ST_ERASE &&
        !s.then_write && o_cpu_halt);
    c_rejected: cover property (cmd_wr && !allowed && s.any);
endmodule : nvp_ctrl

// *** verification/nvp_array_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// array partner: one done pulse per step
// ----------------------------------------
module nvp_array_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire nvp_pkg::nvp_op_t i_op,
    input wire logic [4:0] i_lat,
    output logic o_done
);
    logic [4:0] cnt;
    // latency is set by the bench so both prompt and slow steps occur
    always @(posedge i_clk) begin
        if (i_rst || i_op == nvp_pkg::OP_NONE || o_done) begin
            cnt <= 5'h00;
            o_done <= 1'b0;
        end else begin
            cnt <= cnt + 5'h01;
            o_done <= (cnt == i_lat);
        end
    end
endmodule : nvp_array_model

// *** verification/tb_nvp_ctrl.sv ***
`timescale 1ns/1ps
module tb_nvp_ctrl;
    localparam int POR = 8;
    typedef struct packed {
        logic [7:0] l;
        logic [7:0] a;
        logic [15:0] p;
        logic ee;
        logic [15:0] ad;
        logic wp;
        logic ok;
    } nvp_case_t;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] ra = 8'h00, rwd = 8'h00, mwd = 8'h00, le = 8'h04, ae = 8'h08;
    logic rwr = 1'b0, rrd = 1'b0, mwr = 1'b0, mrd = 1'b0, dbg = 1'b0;
    logic idn = 1'b0, lck = 1'b0, wk = 1'b0, rd_d = 1'b0;
    logic [15:0] ma = 16'h0000, pc = 16'h0100;
    logic [4:0] lat = 5'h02;
    nvp_pkg::nvp_space_t msp = nvp_pkg::SP_FLASH;
    logic [7:0] rdata;
    logic [7:0] rx;
    logic wt, dny, hlt, blk, done, any;
    nvp_pkg::nvp_nvm_req_t req, e;
    logic [7:0] rq[$];
    nvp_pkg::nvp_nvm_req_t nq[$];
    logic [nvp_pkg::PAGE_BYTES-1:0][7:0] eb;
    logic [nvp_pkg::PAGE_BYTES-1:0] em;
    nvp_pkg::nvp_space_t esp;
    logic [15:0] epg;
    int error_cnt = 0;
    int n_checks = 0;
    nvp_case_t cs[9] = '{
        '{8'h00, 8'h00, 16'h1f00, 1'b1, 16'h0010, 1'b0, 1'b1},
        '{8'h04, 8'h00, 16'h0500, 1'b0, 16'h1f00, 1'b0, 1'b0},
        '{8'h04, 8'h02, 16'h0500, 1'b1, 16'h0010, 1'b0, 1'b0},
        '{8'h04, 8'h08, 16'h0500, 1'b0, 16'h0900, 1'b0, 1'b1},
        '{8'h04, 8'h08, 16'h0100, 1'b0, 16'h0500, 1'b0, 1'b1},
        '{8'h04, 8'h08, 16'h0100, 1'b0, 16'h0200, 1'b0, 1'b0},
        '{8'h04, 8'h08, 16'h0100, 1'b0, 16'h0500, 1'b1, 1'b0},
        '{8'h28, 8'h08, 16'h1f00, 1'b1, 16'h0010, 1'b0, 1'b1},
        '{8'h04, 8'h28, 16'h1f00, 1'b0, 16'h0900, 1'b0, 1'b0}
    };
    nvp_ctrl #(.POR_CYCLES(POR)) i_nvp_ctrl (
        .i_clk(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rwd),
        .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdata),
        .i_mem_addr(ma), .i_mem_wdata(mwd), .i_mem_space(msp),
        .i_mem_wr(mwr), .i_mem_rd(mrd), .i_mem_dbg(dbg), .o_mem_wait(wt),
        .o_mem_deny(dny), .i_pc(pc), .i_instr_done(idn),
        .i_dev_locked(lck), .i_wake(wk), .i_loader_end_fuse(le),
        .i_app_code_end_fuse(ae), .o_cpu_halt(hlt),
        .o_loader_blocked(blk), .o_nvm_req(req), .i_nvm_done(done)
    );
    nvp_array_model i_nvp_array_model (
        .i_clk(clk), .i_rst(rst), .i_op(req.op), .i_lat(lat), .o_done(done)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // drivers and expectation model
    // ----------------------------------------
    task automatic chk(input string n, input logic [599:0] x,
                       input logic [599:0] s);
        n_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    function automatic void clr();
        eb = '1;
        em = '0;
        any = 1'b0;
    endfunction : clr
    function automatic void push(input nvp_pkg::nvp_op_t o);
        nvp_pkg::nvp_nvm_req_t r;
        r.op = o;
        r.space = esp;
        r.page = epg;
        r.data = eb;
        r.mask = (esp == nvp_pkg::SP_FLASH) ? '1 : em;
        nq.push_back(r);
    endfunction : push
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        rq.push_back(x);
        @(posedge clk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
    endtask : rd
    task automatic st(input nvp_pkg::nvp_space_t s, input logic [15:0] a,
                      input logic [7:0] d, input logic ok);
        @(posedge clk);
        msp <= s;
        ma <= a;
        mwd <= d;
        mwr <= 1'b1;
        @(posedge clk);
        mwr <= 1'b0;
        if (ok) begin
            eb[a[5:0]] = eb[a[5:0]] & d;
            em[a[5:0]] = 1'b1;
            esp = s;
            epg = {a[15:6], 6'h00};
            any = 1'b1;
        end
    endtask : st
    task automatic cmd(input logic [2:0] c, input logic ok);
        wr(nvp_pkg::ADDR_KEY, nvp_pkg::KEY_SELF_PROG);
        if (ok && any && c != 3'h4) begin
            if (c[1]) push(nvp_pkg::OP_ERASE);
            if (c[0]) push(nvp_pkg::OP_WRITE);
        end
        if (ok && (any || c == 3'h4)) clr();
        wr(nvp_pkg::ADDR_CMD, {5'h00, c});
    endtask : cmd
    task automatic prot(input logic [7:0] v);
        wr(nvp_pkg::ADDR_KEY, nvp_pkg::KEY_IO);
        wr(nvp_pkg::ADDR_PROT, v);
    endtask : prot
    task automatic idle();
        for (int k = 0; k < 400 && nq.size() != 0; k++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : idle
    task automatic boot(input logic [7:0] l, input logic [7:0] a);
        @(posedge clk);
        rst <= 1'b1;
        le <= l;
        ae <= a;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        clr();
        st(nvp_pkg::SP_FLASH, 16'h0901, 8'h00, 1'b0);
        rd(nvp_pkg::ADDR_STATUS, 8'h03);
        repeat (POR + 2) @(posedge clk);
        rd(nvp_pkg::ADDR_STATUS, 8'h00);
    endtask : boot
    // ----------------------------------------
    // monitor: oldest note against each result
    // ----------------------------------------
    always @(posedge clk) begin
        if (rd_d) begin
            rx = rq.size() ? rq.pop_front() : 8'hxx;
            chk("reg_rdata", rx, rdata);
        end
        if (done) begin
            e = nq.size() ? nq.pop_front() : '0;
            chk("nvm_req", e, req);
            chk("cpu_halt", e.space == nvp_pkg::SP_FLASH, hlt);
        end
        rd_d <= rrd;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(98796));
        foreach (cs[i]) begin
            boot(cs[i].l, cs[i].a);
            pc <= cs[i].p;
            if (cs[i].wp) prot(8'h01);
            st(cs[i].ee ? nvp_pkg::SP_EEPROM : nvp_pkg::SP_FLASH, cs[i].ad,
               8'($urandom), 1'b1);
            cmd(3'h1, cs[i].ok);
            idle();
            rd(nvp_pkg::ADDR_STATUS, cs[i].ok ? 8'h00 : 8'h04);
        end
        boot(8'h04, 8'h08);
        pc <= 16'h0100;
        lat <= 5'h10;
        st(nvp_pkg::SP_EEPROM, 16'h0023, 8'ha5, 1'b1);
        st(nvp_pkg::SP_EEPROM, 16'h0023, 8'h3c, 1'b1);
        st(nvp_pkg::SP_EEPROM, 16'h0031, 8'($urandom), 1'b1);
        st(nvp_pkg::SP_FLASH, 16'h0540, 8'h00, 1'b0);
        cmd(3'h2, 1'b1);
        repeat (3) @(posedge clk);
        mrd <= 1'b1;
        #1 chk("mem_wait", 1'b1, wt);
        @(posedge clk);
        mrd <= 1'b0;
        idle();
        st(nvp_pkg::SP_EEPROM, 16'h0012, 8'h00, 1'b1);
        @(posedge clk);
        wk <= 1'b1;
        @(posedge clk);
        wk <= 1'b0;
        clr();
        cmd(3'h1, 1'b1);
        rd(nvp_pkg::ADDR_STATUS, 8'h00);
        lat <= 5'h03;
        st(nvp_pkg::SP_FLASH, 16'h0547, 8'($urandom), 1'b1);
        st(nvp_pkg::SP_FLASH, 16'h0560, 8'($urandom), 1'b1);
        cmd(3'h3, 1'b1);
        idle();
        st(nvp_pkg::SP_FLASH, 16'h0544, 8'h00, 1'b1);
        cmd(3'h4, 1'b1);
        repeat (10) @(posedge clk);
        st(nvp_pkg::SP_FLASH, 16'h0545, 8'h0f, 1'b1);
        cmd(3'h2, 1'b1);
        idle();
        st(nvp_pkg::SP_EEPROM, 16'h0002, 8'h11, 1'b1);
        wr(nvp_pkg::ADDR_KEY, nvp_pkg::KEY_SELF_PROG);
        repeat (5) begin
            @(posedge clk);
            idn <= 1'b1;
            @(posedge clk);
            idn <= 1'b0;
        end
        wr(nvp_pkg::ADDR_CMD, 8'h01);
        wr(nvp_pkg::ADDR_KEY, nvp_pkg::KEY_IO);
        wr(nvp_pkg::ADDR_CMD, 8'h01);
        repeat (20) @(posedge clk);
        cmd(3'h1, 1'b1);
        idle();
        lck <= 1'b1;
        dbg <= 1'b1;
        st(nvp_pkg::SP_FLASH, 16'h0600, 8'h00, 1'b0);
        st(nvp_pkg::SP_USER, 16'h0005, 8'($urandom), 1'b1);
        cmd(3'h1, 1'b1);
        idle();
        lck <= 1'b0;
        dbg <= 1'b0;
        pc <= 16'h0500;
        prot(8'h02);
        rd(nvp_pkg::ADDR_PROT, 8'h00);
        pc <= 16'h0100;
        prot(8'h02);
        rd(nvp_pkg::ADDR_PROT, 8'h02);
        rd(nvp_pkg::ADDR_CMD, 8'h00);
        rd(8'h05, 8'h00);
        #1 chk("loader_blocked", 1'b0, blk);
        @(posedge clk);
        pc <= 16'h0500;
        msp <= nvp_pkg::SP_FLASH;
        ma <= 16'h0100;
        mrd <= 1'b1;
        #1 chk("loader_blocked", 1'b1, blk);
        chk("mem_deny", 1'b1, dny);
        @(posedge clk);
        mrd <= 1'b0;
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule : tb_nvp_ctrl
